// ### hw/light_prox_pkg.sv
// constants for the light and proximity register bank
// Function
// - sensing configuration resets to all zeros, both sensing functions off.
// - config bit 0 selects visible (0) or infrared (1) light results.
// - config bit 1 selects 125 lux (0) or 2000 lux (1) full scale.
// - config bit 2 enables light sensing in the spectrum that bit 0 selects.
// - config bit 3 selects 110mA (0) or 220mA (1) emitter pulses.
// - config bits 6:4 select proximity sleep time; 111 disables sleeping.
// - proximity repeats a 0.54ms conversion then the selected sleep interval.
// - config bit 7 enables proximity sensing; cleared at reset.
// - event register field layout, reset zero; host writes bit 4 as zero.
// - combine select: 0 means either flag, 1 means both flags.
// - open-drain interrupt pulled low while selected flag combination holds.
// - writing zero to a flag clears it; the interrupt releases once the selected flag combination no longer holds.
// - persistence codes need 1, 4, 8 or 16 consecutive qualifying conversions.
// - light flag set when result leaves the threshold window persistently.
// - near flag set at high threshold, cleared at low threshold or write.
// - light thresholds are 12 bits from one byte and one shared nibble.
package light_prox_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_IDENTITY   = 8'h00;
  localparam logic [7:0] ADDR_CONFIG     = 8'h01;
  localparam logic [7:0] ADDR_EVENT      = 8'h02;
  localparam logic [7:0] ADDR_NEAR_LOW   = 8'h03;
  localparam logic [7:0] ADDR_NEAR_HIGH  = 8'h04;
  localparam logic [7:0] ADDR_LT_LOW     = 8'h05;
  localparam logic [7:0] ADDR_LT_NIBBLES = 8'h06;
  localparam logic [7:0] ADDR_LT_HIGH    = 8'h07;
  localparam logic [7:0] ADDR_NEAR_RES   = 8'h08;
  localparam logic [7:0] ADDR_LIGHT_LO   = 8'h09;
  localparam logic [7:0] ADDR_LIGHT_HI   = 8'h0a;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CONFIG_RST     = 8'h00;
  localparam logic [7:0] EVENT_RST      = 8'h00;
  localparam logic [7:0] NEAR_LOW_RST   = 8'h00;
  localparam logic [7:0] NEAR_HIGH_RST  = 8'hff;
  localparam logic [7:0] LT_LOW_RST     = 8'h00;
  localparam logic [7:0] LT_NIBBLES_RST = 8'hf0;
  localparam logic [7:0] LT_HIGH_RST    = 8'hff;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CFG_SPECTRUM  = 0;
  localparam int CFG_RANGE     = 1;
  localparam int CFG_LIGHT_EN  = 2;
  localparam int CFG_DRIVE     = 3;
  localparam int CFG_SLEEP_LSB = 4;
  localparam int CFG_NEAR_EN   = 7;
  localparam int EVT_COMBINE   = 0;
  localparam int EVT_LP_LSB    = 1;
  localparam int EVT_LFLAG     = 3;
  localparam int EVT_ZERO      = 4;
  localparam int EVT_NP_LSB    = 5;
  localparam int EVT_NFLAG     = 7;

  localparam logic [2:0] SLEEP_NONE = 3'h7;

  // persistence code to run length, codes 00..11
  localparam logic [4:0] PERSIST_N [4] = '{5'h01, 5'h04, 5'h08, 5'h10};

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int CONV_TIME_NS  = 540000;
  localparam int CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  // sleep times in microseconds for codes 000..110
  localparam int SLEEP_TIME_US [7] = '{800000, 400000, 200000, 100000, 75000, 50000, 12500};
  localparam int NS_PER_US     = 1000;

  typedef enum logic [1:0] {
    NEAR_IDLE    = 2'b00,
    NEAR_CONVERT = 2'b01,
    NEAR_SLEEP   = 2'b11
  } near_state_t;

endpackage

// ### hw/light_prox_regs.sv
// register bank, proximity sequencer and interrupt pin of the light/proximity sensor
`timescale 1ns/1ps
`default_nettype none

module light_prox_regs
  import light_prox_pkg::*;
#(
  parameter logic [7:0] CHIP_IDENTITY = 8'h5a, // arbitrary value
  parameter int         CONV_CYC      = CONV_CYCLES,
  parameter int         SLEEP_CYC [7] = '{
    SLEEP_TIME_US[0] * NS_PER_US / CLK_PERIOD_NS,
    SLEEP_TIME_US[1] * NS_PER_US / CLK_PERIOD_NS,
    SLEEP_TIME_US[2] * NS_PER_US / CLK_PERIOD_NS,
    SLEEP_TIME_US[3] * NS_PER_US / CLK_PERIOD_NS,
    SLEEP_TIME_US[4] * NS_PER_US / CLK_PERIOD_NS,
    SLEEP_TIME_US[5] * NS_PER_US / CLK_PERIOD_NS,
    SLEEP_TIME_US[6] * NS_PER_US / CLK_PERIOD_NS}
)(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // register port behind the serial target engine
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // converter side
  input  wire logic        near_sample_valid,
  input  wire logic [7:0]  near_sample,
  input  wire logic        light_sample_valid,
  input  wire logic [11:0] light_sample,
  output logic             light_sense_enable,
  output logic             light_full_scale_select,
  output logic             light_spectrum_select,
  output logic             near_convert,
  output logic             emitter_sink_pin,
  output logic             emitter_drive_strength,
  // open-drain interrupt, active low
  output logic             int_n_out,
  output logic             int_n_oe
);

  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  generate
    if (CONV_CYC < 1) begin : g_bad_conv
      $error("conversion length must be at least one cycle");
    end
    for (genvar g = 0; g < 7; g++) begin : g_chk
      if (SLEEP_CYC[g] < 1) begin : g_bad_sleep
        $error("sleep length must be at least one cycle");
      end
    end
  endgenerate

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0]  sensing_config;
  logic [7:0]  event_control_status;
  logic [7:0]  near_low_threshold;
  logic [7:0]  near_high_threshold;
  logic [7:0]  light_threshold_low_byte;
  logic [7:0]  light_threshold_nibbles;
  logic [7:0]  light_threshold_high_byte;
  logic [7:0]  near_result;
  logic [11:0] light_result;

  logic        wr_config;
  logic        wr_event;
  logic        near_flag;
  logic        light_window_flag;
  logic        next_near_flag;
  logic        next_light_flag;

  assign wr_config = reg_wr && (reg_addr == ADDR_CONFIG);
  assign wr_event  = reg_wr && (reg_addr == ADDR_EVENT);
  assign near_flag         = event_control_status[EVT_NFLAG];
  assign light_window_flag = event_control_status[EVT_LFLAG];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      sensing_config <= CONFIG_RST;
    else if (wr_config)
      sensing_config <= reg_wdata;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      near_low_threshold        <= NEAR_LOW_RST;
      near_high_threshold       <= NEAR_HIGH_RST;
      light_threshold_low_byte  <= LT_LOW_RST;
      light_threshold_nibbles   <= LT_NIBBLES_RST;
      light_threshold_high_byte <= LT_HIGH_RST;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        ADDR_NEAR_LOW:   near_low_threshold        <= reg_wdata;
        ADDR_NEAR_HIGH:  near_high_threshold       <= reg_wdata;
        ADDR_LT_LOW:     light_threshold_low_byte  <= reg_wdata;
        ADDR_LT_NIBBLES: light_threshold_nibbles   <= reg_wdata;
        ADDR_LT_HIGH:    light_threshold_high_byte <= reg_wdata;
        default:         ;
      endcase
    end
  end

  // flag bits clear from the host, the near flag also at the low threshold; fields store; bit 4 is held at zero
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      event_control_status <= EVENT_RST;
    else
    begin
      event_control_status[EVT_NFLAG] <= next_near_flag;
      event_control_status[EVT_LFLAG] <= next_light_flag;
      event_control_status[EVT_ZERO]  <= 1'b0;
      if (wr_event)
      begin
        event_control_status[EVT_NP_LSB +: 2] <= reg_wdata[EVT_NP_LSB +: 2];
        event_control_status[EVT_LP_LSB +: 2] <= reg_wdata[EVT_LP_LSB +: 2];
        event_control_status[EVT_COMBINE]     <= reg_wdata[EVT_COMBINE];
      end
    end
  end

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  assign light_spectrum_select   = sensing_config[CFG_SPECTRUM];
  assign light_full_scale_select = sensing_config[CFG_RANGE];
  assign light_sense_enable      = sensing_config[CFG_LIGHT_EN];
  assign emitter_drive_strength  = sensing_config[CFG_DRIVE];

  // ----------------------------------------
  // proximity sequencer
  // ----------------------------------------
  near_state_t near_state;
  logic [31:0] near_count;
  logic [2:0]  sleep_sel;
  logic [31:0] sleep_len;

  assign sleep_sel = sensing_config[CFG_SLEEP_LSB +: 3];
  assign sleep_len = (sleep_sel == SLEEP_NONE) ? 32'h1
                                               : 32'(SLEEP_CYC[sleep_sel]);

  // a new sleep code also applies to the sleep already in progress; disabling aborts at once
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      near_state <= NEAR_IDLE;
      near_count <= 32'h0;
    end
    else if (!sensing_config[CFG_NEAR_EN])
    begin
      near_state <= NEAR_IDLE;
      near_count <= 32'h0;
    end
    else
    begin
      case (near_state)
        NEAR_IDLE:
        begin
          near_state <= NEAR_CONVERT;
          near_count <= 32'h0;
        end
        NEAR_CONVERT:
          if (near_count >= 32'(CONV_CYC - 1))
          begin
            near_state <= NEAR_SLEEP;
            near_count <= 32'h0;
          end
          else
            near_count <= near_count + 32'h1;
        NEAR_SLEEP:
          if (near_count >= sleep_len - 32'h1)
          begin
            near_state <= NEAR_CONVERT;
            near_count <= 32'h0;
          end
          else
            near_count <= near_count + 32'h1;
        default:
        begin
          near_state <= NEAR_IDLE;
          near_count <= 32'h0;
        end
      endcase
    end
  end

  assign near_convert     = (near_state == NEAR_CONVERT);
  assign emitter_sink_pin = (near_state == NEAR_CONVERT);

  // ----------------------------------------
  // results
  // ----------------------------------------
  logic near_take;
  logic light_take;

  assign near_take  = near_sample_valid && sensing_config[CFG_NEAR_EN];
  assign light_take = light_sample_valid && sensing_config[CFG_LIGHT_EN];

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      near_result  <= 8'h00;
      light_result <= 12'h000;
    end
    else
    begin
      if (near_take)
        near_result <= near_sample;
      if (light_take)
        light_result <= light_sample;
    end
  end

  // ----------------------------------------
  // persistence and flags
  // ----------------------------------------
  logic [11:0] light_low_level;
  logic [11:0] light_high_level;
  logic        light_outside;
  logic        near_at_high;
  logic        near_at_low;
  logic [4:0]  light_need;
  logic [4:0]  near_need;
  logic [4:0]  light_run;
  logic [4:0]  near_high_run;
  logic [4:0]  near_low_run;
  logic        light_set;
  logic        near_set;
  logic        near_auto_clear;

  assign light_low_level  = {light_threshold_nibbles[3:0], light_threshold_low_byte};
  assign light_high_level = {light_threshold_high_byte, light_threshold_nibbles[7:4]};
  // window edges count as outside, both bounds inclusive
  assign light_outside = (light_sample <= light_low_level) ||
                         (light_sample >= light_high_level);
  assign near_at_high = (near_sample >= near_high_threshold);
  assign near_at_low  = (near_sample <= near_low_threshold);

  assign light_need = PERSIST_N[event_control_status[EVT_LP_LSB +: 2]];
  assign near_need  = PERSIST_N[event_control_status[EVT_NP_LSB +: 2]];

  // run counters saturate at the longest run so a long streak never wraps
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      light_run     <= 5'h0;
      near_high_run <= 5'h0;
      near_low_run  <= 5'h0;
    end
    else
    begin
      if (light_take)
        light_run <= !light_outside ? 5'h0 :
                     (light_run == PERSIST_N[3]) ? light_run : light_run + 5'h1;
      if (near_take)
      begin
        near_high_run <= !near_at_high ? 5'h0 :
                         (near_high_run == PERSIST_N[3]) ? near_high_run
                                                         : near_high_run + 5'h1;
        near_low_run  <= !near_at_low ? 5'h0 :
                         (near_low_run == PERSIST_N[3]) ? near_low_run
                                                        : near_low_run + 5'h1;
      end
    end
  end

  assign light_set = light_take && light_outside &&
                     (light_run + 5'h1 >= light_need);
  assign near_set  = near_take && near_at_high &&
                     (near_high_run + 5'h1 >= near_need);
  assign near_auto_clear = near_take && near_at_low &&
                           (near_low_run + 5'h1 >= near_need);

  // a set in the same cycle as a clear wins, so no event is lost
  always_comb
  begin
    next_near_flag  = near_flag;
    next_light_flag = light_window_flag;
    if (near_auto_clear || (wr_event && !reg_wdata[EVT_NFLAG]))
      next_near_flag = 1'b0;
    if (near_set)
      next_near_flag = 1'b1;
    if (wr_event && !reg_wdata[EVT_LFLAG])
      next_light_flag = 1'b0;
    if (light_set)
      next_light_flag = 1'b1;
  end

  // ----------------------------------------
  // interrupt pin
  // ----------------------------------------
  logic int_active;

  assign int_active = event_control_status[EVT_COMBINE] ?
                      (near_flag && light_window_flag) :
                      (near_flag || light_window_flag);
  assign int_n_out = 1'b0;
  assign int_n_oe  = int_active;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_IDENTITY:   reg_rdata <= CHIP_IDENTITY;
        ADDR_CONFIG:     reg_rdata <= sensing_config;
        ADDR_EVENT:      reg_rdata <= event_control_status;
        ADDR_NEAR_LOW:   reg_rdata <= near_low_threshold;
        ADDR_NEAR_HIGH:  reg_rdata <= near_high_threshold;
        ADDR_LT_LOW:     reg_rdata <= light_threshold_low_byte;
        ADDR_LT_NIBBLES: reg_rdata <= light_threshold_nibbles;
        ADDR_LT_HIGH:    reg_rdata <= light_threshold_high_byte;
        ADDR_NEAR_RES:   reg_rdata <= near_result;
        ADDR_LIGHT_LO:   reg_rdata <= light_result[7:0];
        ADDR_LIGHT_HI:   reg_rdata <= {4'h0, light_result[11:8]};
        default:         reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  config_write_a: assert property (wr_config |=> sensing_config == $past(reg_wdata))
    else $error("config write not stored");
  spectrum_out_a: assert property (wr_config |=> light_spectrum_select == $past(reg_wdata[CFG_SPECTRUM]))
    else $error("spectrum select mismatch");
  range_out_a: assert property (wr_config |=> light_full_scale_select == $past(reg_wdata[CFG_RANGE]))
    else $error("full scale select mismatch");
  light_enable_a: assert property (!light_sense_enable && light_sample_valid |=> $stable(light_result))
    else $error("light result changed while disabled");
  drive_level_a: assert property (wr_config |=> emitter_drive_strength == $past(reg_wdata[CFG_DRIVE]))
    else $error("drive strength mismatch");
  no_sleep_a: assert property (near_state == NEAR_SLEEP && sleep_sel == SLEEP_NONE && sensing_config[CFG_NEAR_EN] |=> near_state == NEAR_CONVERT)
    else $error("sleep not skipped");
  conv_exit_a: assert property (near_state == NEAR_CONVERT && near_count < 32'(CONV_CYC - 1) && sensing_config[CFG_NEAR_EN] |=> near_state == NEAR_CONVERT)
    else $error("conversion ended early");
  near_off_a: assert property (!sensing_config[CFG_NEAR_EN] |=> near_state == NEAR_IDLE && !emitter_sink_pin)
    else $error("proximity active while disabled");
  bit4_zero_a: assert property (reg_rd && reg_addr == ADDR_EVENT |=> !reg_rdata[EVT_ZERO])
    else $error("event bit 4 reads one");
  combine_and_a: assert property (event_control_status[EVT_COMBINE] && int_n_oe |-> near_flag && light_window_flag)
    else $error("and-combine asserted with one flag");
  pin_low_a: assert property (!event_control_status[EVT_COMBINE] && (near_flag || light_window_flag) |-> int_n_oe && !int_n_out)
    else $error("interrupt pin not pulled low");
  host_clear_a: assert property (wr_event && !reg_wdata[EVT_LFLAG] && !light_set |=> !light_window_flag)
    else $error("light flag not cleared");
  persist_a: assert property ($rose(near_flag) |-> $past(near_high_run) + 5'h1 >= $past(near_need))
    else $error("near flag set before persistence met");
  window_a: assert property ($rose(light_window_flag) |-> $past(light_outside && light_take))
    else $error("light flag set inside window");

endmodule

`default_nettype wire

// ### testbench/host_model.sv
// host-side model: register port accesses and converter result strobes
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic        sys_clk,
  input  wire logic [7:0]  reg_rdata,
  output logic      [7:0]  reg_addr,
  output logic             reg_wr,
  output logic      [7:0]  reg_wdata,
  output logic             reg_rd,
  output logic             near_sample_valid,
  output logic      [7:0]  near_sample,
  output logic             light_sample_valid,
  output logic      [11:0] light_sample
);
  initial
  begin
    reg_addr           = 8'h00;
    reg_wr             = 1'b0;
    reg_wdata          = 8'h00;
    reg_rd             = 1'b0;
    near_sample_valid  = 1'b0;
    near_sample        = 8'h00;
    light_sample_valid = 1'b0;
    light_sample       = 12'h000;
  end

  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a != 8'h00) // identity register is never touched
    begin
      @(posedge sys_clk);
      #1;
      reg_addr  = a;
      reg_wdata = (a == 8'h02) ? (d & 8'hef) : d; // reserved bit sent as zero
      reg_wr    = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~reg_wdata;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'h00;
    if (a != 8'h00)
    begin
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
    end
  endtask

  task automatic near(input logic [7:0] s);
    @(posedge sys_clk);
    #1;
    near_sample       = s;
    near_sample_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    near_sample_valid = 1'b0;
    near_sample       = ~s;
  endtask

  task automatic light(input logic [11:0] s);
    @(posedge sys_clk);
    #1;
    light_sample       = s;
    light_sample_valid = 1'b1;
    @(posedge sys_clk);
    #1;
    light_sample_valid = 1'b0;
    light_sample       = ~s;
  endtask
endmodule

`default_nettype wire

// ### testbench/tb_top.sv
// self-checking testbench for the light/proximity register bank
`timescale 1ns/1ps
`default_nettype none

module tb_top
  import light_prox_pkg::*;
;
  // short counts keep the sequencer runs brief
  localparam int CONV = 10;
  localparam int SLP [7] = '{20, 18, 16, 14, 12, 10, 8};

  logic        sys_clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic        reg_wr;
  logic [7:0]  reg_wdata;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        near_sample_valid;
  logic [7:0]  near_sample;
  logic        light_sample_valid;
  logic [11:0] light_sample;
  logic        light_sense_enable;
  logic        light_full_scale_select;
  logic        light_spectrum_select;
  logic        near_convert;
  logic        emitter_sink_pin;
  logic        emitter_drive_strength;
  logic        int_n_out;
  logic        int_n_oe;
  int          mismatches;
  int          comparisons;
  // pulled-up open-drain interrupt line
  wire         int_line = int_n_oe ? int_n_out : 1'b1;

  light_prox_regs #(.CONV_CYC(CONV), .SLEEP_CYC(SLP)) i_light_prox_regs (
    .sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .near_sample_valid(near_sample_valid), .near_sample(near_sample),
    .light_sample_valid(light_sample_valid), .light_sample(light_sample),
    .light_sense_enable(light_sense_enable),
    .light_full_scale_select(light_full_scale_select),
    .light_spectrum_select(light_spectrum_select), .near_convert(near_convert),
    .emitter_sink_pin(emitter_sink_pin), .emitter_drive_strength(emitter_drive_strength),
    .int_n_out(int_n_out), .int_n_oe(int_n_oe));

  host_model i_host_model (
    .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .near_sample_valid(near_sample_valid),
    .near_sample(near_sample), .light_sample_valid(light_sample_valid),
    .light_sample(light_sample));

  always #2.5 sys_clk = ~sys_clk;

  task automatic check_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask

  task automatic check_bit(input string n, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %b seen %b", n, e, g);
      mismatches++;
    end
  endtask

  task automatic check_count(input string n, input int e, input int g);
    comparisons++;
    if (g != e)
    begin
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
      mismatches++;
    end
  endtask

  task automatic t_reset_values;
    logic [7:0] d;
    logic [7:0] ex [10];
    ex = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'hf0, 8'hff, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 10; i++)
    begin
      i_host_model.rd(8'(i + 1), d);
      check_byte("reset value", ex[i], d);
    end
    i_host_model.rd(8'h0b, d);
    check_byte("unmapped read", 8'h00, d);
    check_bit("int released", 1'b1, int_line);
  endtask

  task automatic t_config;
    logic [7:0] d;
    logic [7:0] v [4];
    v = '{8'h0f, 8'h05, 8'h0a, 8'h00};
    for (int i = 0; i < 4; i++)
    begin
      i_host_model.wr(8'h01, v[i]);
      i_host_model.rd(8'h01, d);
      check_byte("config readback", v[i], d);
      check_bit("spectrum", v[i][0], light_spectrum_select);
      check_bit("full scale", v[i][1], light_full_scale_select);
      check_bit("light enable", v[i][2], light_sense_enable);
      check_bit("drive", v[i][3], emitter_drive_strength);
    end
  endtask

  task automatic t_sequencer;
    logic [2:0] c [8];
    int         hi;
    int         lo;
    c = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    for (int i = 0; i < 8; i++)
    begin
      i_host_model.wr(8'h01, {1'b1, c[i], 4'h0});
      lo = 0;
      while (near_convert !== 1'b1 && lo < 100)
      begin
        @(posedge sys_clk);
        #1;
        lo++;
      end
      check_bit("emitter", 1'b1, emitter_sink_pin);
      hi = 0;
      while (near_convert === 1'b1 && hi < 1000)
      begin
        hi++;
        @(posedge sys_clk);
        #1;
      end
      check_count("conversion cycles", CONV, hi);
      lo = 0;
      while (near_convert === 1'b0 && lo < 1000)
      begin
        lo++;
        @(posedge sys_clk);
        #1;
      end
      check_count("sleep cycles", (c[i] == 3'h7) ? 1 : SLP[c[i]], lo);
      i_host_model.wr(8'h01, 8'h00);
      @(posedge sys_clk);
      #1;
      check_bit("disabled convert", 1'b0, near_convert);
    end
  endtask

  task automatic t_near_persist;
    logic [7:0] d;
    int         n [4];
    n = '{1, 4, 8, 16};
    i_host_model.wr(8'h03, 8'h20);
    i_host_model.wr(8'h04, 8'h80);
    i_host_model.wr(8'h01, 8'h80);
    for (int c = 0; c < 4; c++)
    begin
      // a mid-window sample breaks any earlier run
      i_host_model.near(8'h50);
      i_host_model.wr(8'h02, {1'b0, 2'(c), 5'h00});
      repeat (n[c] - 1) i_host_model.near(8'h90);
      i_host_model.rd(8'h02, d);
      check_byte("near not yet", {1'b0, 2'(c), 5'h00}, d);
      check_bit("int idle", 1'b1, int_line);
      i_host_model.near(8'h80);
      i_host_model.rd(8'h02, d);
      check_byte("near set", {1'b1, 2'(c), 5'h00}, d);
      check_bit("int either", 1'b0, int_line);
    end
    repeat (15) i_host_model.near(8'h20);
    i_host_model.rd(8'h02, d);
    check_byte("near held", 8'he0, d);
    i_host_model.near(8'h20);
    i_host_model.rd(8'h02, d);
    check_byte("near auto clear", 8'h60, d);
    check_bit("int off", 1'b1, int_line);
    i_host_model.rd(8'h08, d);
    check_byte("near result", 8'h20, d);
  endtask

  task automatic t_light_combine;
    logic [7:0] d;
    i_host_model.wr(8'h01, 8'h84);
    i_host_model.wr(8'h05, 8'h00);
    i_host_model.wr(8'h06, 8'h01);
    i_host_model.wr(8'h07, 8'h80);
    i_host_model.wr(8'h02, 8'h00);
    i_host_model.light(12'h400);
    i_host_model.rd(8'h02, d);
    check_byte("light inside", 8'h00, d);
    i_host_model.light(12'h800);
    i_host_model.rd(8'h02, d);
    check_byte("light high edge", 8'h08, d);
    check_bit("int light", 1'b0, int_line);
    i_host_model.rd(8'h09, d);
    check_byte("light low byte", 8'h00, d);
    i_host_model.rd(8'h0a, d);
    check_byte("light high nibble", 8'h08, d);
    i_host_model.wr(8'h02, 8'h09);
    check_bit("int both pending", 1'b1, int_line);
    i_host_model.near(8'hff);
    i_host_model.rd(8'h02, d);
    check_byte("both flags", 8'h89, d);
    check_bit("int both", 1'b0, int_line);
    i_host_model.wr(8'h02, 8'h01);
    check_bit("int cleared", 1'b1, int_line);
    i_host_model.rd(8'h02, d);
    check_byte("flags cleared", 8'h01, d);
    i_host_model.light(12'h100);
    i_host_model.rd(8'h02, d);
    check_byte("light low edge", 8'h09, d);
    i_host_model.wr(8'h02, 8'h02);
    i_host_model.light(12'h400);
    repeat (3) i_host_model.light(12'h900);
    i_host_model.rd(8'h02, d);
    check_byte("light not yet", 8'h02, d);
    i_host_model.light(12'h900);
    i_host_model.rd(8'h02, d);
    check_byte("light persist set", 8'h0a, d);
    i_host_model.wr(8'h01, 8'h00);
    i_host_model.light(12'h123);
    i_host_model.near(8'h11);
    i_host_model.rd(8'h09, d);
    check_byte("light ignored", 8'h00, d);
    i_host_model.rd(8'h08, d);
    check_byte("near ignored", 8'hff, d);
  endtask

  // reset in mid-run must bring back the power-on state with a flag pending
  task automatic t_mid_reset;
    logic [7:0] d;
    i_host_model.wr(8'h01, 8'h8c);
    i_host_model.near(8'hff);
    check_bit("int before reset", 1'b0, int_line);
    @(posedge sys_clk);
    #1;
    rstn = 1'b0;
    @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    i_host_model.rd(8'h01, d);
    check_byte("config after reset", 8'h00, d);
    i_host_model.rd(8'h02, d);
    check_byte("event after reset", 8'h00, d);
    check_bit("int after reset", 1'b1, int_line);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // -----------------------------------------
  // watchdog: tests need well under 50 us
  // -----------------------------------------
  initial
  begin
    #50000;
    mismatches++;
    end_of_test();
  end

  initial
  begin
    mismatches  = 0;
    comparisons = 0;
    sys_clk     = 1'b0;
    rstn        = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    t_reset_values();
    t_config();
    t_sequencer();
    t_near_persist();
    t_light_combine();
    t_mid_reset();
    end_of_test();
  end
endmodule

`default_nettype wire
